// *** verilog/pao_port_override.sv ***
// Purpose: Port F/G function takeover, port A and control registers
// Assumes: Pins synchronous to aclk; test controller and LCD are outside
// Notes:   Only one write and one read are in flight at a time
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module pao_port_override #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [7:0]        pa_in,
    output logic [7:0]             pa_out,
    output logic [7:0]             pa_oe,
    output logic [7:0]             pa_pullup,
    input  wire logic [7:0]        pf_in,
    output logic [7:0]             pf_out,
    output logic [7:0]             pf_oe,
    output logic [7:0]             pf_pullup,
    input  wire logic [5:0]        pg_in,
    output logic [5:0]             pg_out,
    output logic [5:0]             pg_oe,
    output logic [5:0]             pg_pullup,
    input  wire logic              scan_fuse_en,
    input  wire logic              instr_shift_state,
    input  wire logic              data_shift_state,
    input  wire logic              scan_tdo,
    input  wire logic              lcd_on,
    input  wire logic [2:0]        lcd_port_mask,
    input  wire logic              reset_pin_disable_fuse,
    output logic                   scan_if_enable,
    output logic                   scan_tdi,
    output logic                   scan_tms,
    output logic                   scan_tck,
    output logic                   counter_zero_ext_clock,
    output logic                   counter_one_ext_clock,
    output logic                   ext_reset_n,
    output logic [4:0]             lcd_seg_route,
    output logic                   global_pullup_off,
    output logic                   vector_select,
    output logic                   vector_change_en
);

    localparam int NPIN = pao_pkg::NPIN;
    localparam int FB   = pao_pkg::PA_W;
    localparam int GB   = pao_pkg::PA_W + pao_pkg::PF_W;

    // Software registers
    logic [7:0] port_a_output_data;
    logic [7:0] port_a_direction;
    logic [7:0] pf_data;
    logic [7:0] pf_dir;
    logic [4:0] pg_data;
    logic [4:0] pg_dir;
    logic [7:0] mcu_control;
    logic [5:0] rd_idx;

    // Control bit fan-out
    assign global_pullup_off = mcu_control[pao_pkg::MCU_PU_OFF];
    assign vector_select     = mcu_control[pao_pkg::MCU_VSEL];
    assign vector_change_en  = mcu_control[pao_pkg::MCU_VCE];
    assign scan_if_enable    = scan_fuse_en
                             & ~mcu_control[pao_pkg::MCU_SCAN_DIS];

    // Segment ownership of port G by LCD enable and port mask
    wire own_g4 = lcd_on & (lcd_port_mask > pao_pkg::LCD_PM_G4);
    wire own_g3 = lcd_on & (lcd_port_mask > pao_pkg::LCD_PM_G3);
    wire own_g2 = lcd_on;
    wire own_g10 = lcd_on & (lcd_port_mask > pao_pkg::LCD_PM_G10);
    wire shifting = instr_shift_state | data_shift_state;

    // Segment switch enables, indexed by port G bit
    assign lcd_seg_route = {own_g4, own_g3, own_g2, own_g10, own_g10};

    // Flattened pin vectors, A then F then G
    wire [NPIN-1:0] all_in   = {pg_in, pf_in, pa_in};
    wire [NPIN-1:0] all_data = {1'b0, pg_data, pf_data,
                                port_a_output_data};
    wire [NPIN-1:0] all_dir  = {1'b0, pg_dir, pf_dir, port_a_direction};
    logic [NPIN-1:0] all_out;
    logic [NPIN-1:0] all_oe;
    logic [NPIN-1:0] all_pu;
    logic [NPIN-1:0] all_din;
    pao_pkg::pao_ovr_type ovr [NPIN];

    // Takeover table; unlisted pins keep no override
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            ovr[i] = pao_pkg::OVR_NONE;
        end
        for (int i = pao_pkg::PF_TCK; i <= pao_pkg::PF_TDI; i++) begin
            ovr[FB+i].pullup_override_en       = scan_if_enable;
            ovr[FB+i].pullup_override_val      = 1'b1;
            ovr[FB+i].direction_override_en    = scan_if_enable;
            ovr[FB+i].input_enable_override_en = scan_if_enable;
        end
        // Only the test clock keeps a digital input path
        ovr[FB+pao_pkg::PF_TCK].input_enable_override_val = 1'b1;
        // Drive only in shift states, pulled high otherwise
        ovr[FB+pao_pkg::PF_TDO].direction_override_val = shifting;
        ovr[FB+pao_pkg::PF_TDO].out_value_override_en = scan_if_enable;
        ovr[FB+pao_pkg::PF_TDO].out_value_override_val = scan_tdo;
        // Reset pin: input only, pull-up held on
        ovr[GB+pao_pkg::PG_RST] = '{1'b1, 1'b1, 1'b1, 1'b0,
                                    1'b0, 1'b0, 1'b0, 1'b0};
        // Segment pins: counter pin G4 goes output, others analog
        ovr[GB+4] = '{own_g4, 1'b0, own_g4, 1'b1,
                      1'b0, 1'b0, own_g4, 1'b0};
        ovr[GB+3] = '{own_g3, 1'b0, own_g3, 1'b0,
                      1'b0, 1'b0, own_g3, 1'b0};
        ovr[GB+2] = '{own_g2, 1'b0, own_g2, 1'b0,
                      1'b0, 1'b0, own_g2, 1'b0};
        ovr[GB+1] = '{own_g10, 1'b0, own_g10, 1'b0,
                      1'b0, 1'b0, own_g10, 1'b0};
        ovr[GB+0] = '{own_g10, 1'b0, own_g10, 1'b0,
                      1'b0, 1'b0, own_g10, 1'b0};
    end

    // One override cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            pao_pin_cell u_cell (
                .ovr        (ovr[gi]),
                .port_out   (all_data[gi]),
                .port_dir   (all_dir[gi]),
                .pin_in     (all_in[gi]),
                .pullup_off (global_pullup_off),
                .pin_out    (all_out[gi]),
                .pin_oe     (all_oe[gi]),
                .pin_pullup (all_pu[gi]),
                .pin_din    (all_din[gi])
            );
        end
    endgenerate

    // Pin outputs per port
    assign pa_out    = all_out[FB-1:0];
    assign pa_oe     = all_oe[FB-1:0];
    assign pa_pullup = all_pu[FB-1:0];
    assign pf_out    = all_out[GB-1:FB];
    assign pf_oe     = all_oe[GB-1:FB];
    assign pf_pullup = all_pu[GB-1:FB];
    assign pg_out    = all_out[NPIN-1:GB];
    assign pg_oe     = all_oe[NPIN-1:GB];
    assign pg_pullup = all_pu[NPIN-1:GB];

    // Test pins; controller samples and shifts on the test clock
    assign scan_tck = all_din[FB+pao_pkg::PF_TCK];
    assign scan_tdi = pf_in[pao_pkg::PF_TDI];
    assign scan_tms = pf_in[pao_pkg::PF_TMS];

    // Counter sources; read low while the LCD owns the pin
    assign counter_zero_ext_clock = all_din[GB+pao_pkg::PG_CK0];
    assign counter_one_ext_clock  = all_din[GB+pao_pkg::PG_CK1];

    // Fuse programmed (low) turns the reset pin into plain input
    assign ext_reset_n = reset_pin_disable_fuse
                       ? pg_in[pao_pkg::PG_RST] : 1'b1;

    // Write decode; address and data are taken together
    wire       wr_go  = awvalid & wvalid & ~bvalid;
    wire [5:0] w_idx  = awaddr[7:2];
    wire       w_top  = (awaddr[ADDR_W-1:8] == '0);
    wire       w_lane = wr_go & w_top & wstrb[0];
    wire [7:0] wb     = wdata[7:0];
    wire       w_hit  = w_top & (w_idx == pao_pkg::IDX_PA_PIN
                      || w_idx == pao_pkg::IDX_PA_DIR
                      || w_idx == pao_pkg::IDX_PA_OUT
                      || w_idx == pao_pkg::IDX_PF_PIN
                      || w_idx == pao_pkg::IDX_PF_DIR
                      || w_idx == pao_pkg::IDX_PF_OUT
                      || w_idx == pao_pkg::IDX_PG_PIN
                      || w_idx == pao_pkg::IDX_PG_DIR
                      || w_idx == pao_pkg::IDX_PG_OUT
                      || w_idx == pao_pkg::IDX_MCU);
    assign awready = wr_go;
    assign wready  = wr_go;

    // Register writes; pin level registers ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_output_data <= pao_pkg::REG_RESET;
            port_a_direction   <= pao_pkg::REG_RESET;
            pf_data            <= pao_pkg::REG_RESET;
            pf_dir             <= pao_pkg::REG_RESET;
            pg_data            <= pao_pkg::REG_RESET[4:0];
            pg_dir             <= pao_pkg::REG_RESET[4:0];
            mcu_control        <= pao_pkg::REG_RESET;
        end else if (w_lane) begin
            case (w_idx)
                pao_pkg::IDX_PA_OUT: port_a_output_data <= wb;
                pao_pkg::IDX_PA_DIR: port_a_direction <= wb;
                pao_pkg::IDX_PF_OUT: pf_data <= wb;
                pao_pkg::IDX_PF_DIR: pf_dir <= wb;
                pao_pkg::IDX_PG_OUT: pg_data <= wb[4:0];
                pao_pkg::IDX_PG_DIR: pg_dir <= wb[4:0];
                pao_pkg::IDX_MCU:
                    mcu_control <= wb & pao_pkg::MCU_RW_MASK;
                default: ;
            endcase
        end
    end

    // Write response, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= pao_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= w_hit ? pao_pkg::RESP_OKAY : pao_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read decode and selection
    wire       rd_go = arvalid & ~rvalid;
    wire [5:0] r_idx = araddr[7:2];
    wire       r_top = (araddr[ADDR_W-1:8] == '0);
    wire [7:0] pa_lv = all_din[FB-1:0];
    wire [7:0] pf_lv = all_din[GB-1:FB];
    wire [7:0] pg_lv = {2'b00, all_din[NPIN-1:GB]};
    wire [8:0] r_sel =
        (r_idx == pao_pkg::IDX_PA_PIN) ? {1'b1, pa_lv} :
        (r_idx == pao_pkg::IDX_PA_DIR) ? {1'b1, port_a_direction} :
        (r_idx == pao_pkg::IDX_PA_OUT) ? {1'b1, port_a_output_data} :
        (r_idx == pao_pkg::IDX_PF_PIN) ? {1'b1, pf_lv} :
        (r_idx == pao_pkg::IDX_PF_DIR) ? {1'b1, pf_dir} :
        (r_idx == pao_pkg::IDX_PF_OUT) ? {1'b1, pf_data} :
        (r_idx == pao_pkg::IDX_PG_PIN) ? {1'b1, pg_lv} :
        (r_idx == pao_pkg::IDX_PG_DIR) ? {4'b1000, pg_dir} :
        (r_idx == pao_pkg::IDX_PG_OUT) ? {4'b1000, pg_data} :
        (r_idx == pao_pkg::IDX_MCU)    ? {1'b1, mcu_control} :
        9'h000;
    wire       r_hit = r_top & r_sel[8];
    assign arready = rd_go;

    // Read data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= pao_pkg::RESP_OKAY;
            rd_idx <= 6'h00;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, r_hit ? r_sel[7:0] : 8'h00};
            rresp  <= r_hit ? pao_pkg::RESP_OKAY : pao_pkg::RESP_SLVERR;
            rd_idx <= r_top ? r_idx : 6'h3F;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks on the takeover and the register file
    property p_scan_takes_upper;
        @(posedge aclk) disable iff (!aresetn)
        scan_if_enable |-> pf_oe[7] == 1'b0 && pf_oe[5:4] == 2'b00
            && pf_oe[6] == shifting;
    endproperty
    a_scan_takes_upper: assert property (p_scan_takes_upper)
        else $error("port F upper bits not taken by scan");

    property p_tdo_idle_pulled;
        @(posedge aclk) disable iff (!aresetn)
        scan_if_enable && !shifting |-> !pf_oe[6] && pf_pullup[6];
    endproperty
    a_tdo_idle_pulled: assert property (p_tdo_idle_pulled)
        else $error("test output not released outside shift");

    property p_scan_inputs;
        @(posedge aclk) disable iff (!aresetn)
        scan_if_enable |-> pf_pullup[7:4] == 4'hF
            && scan_tck == pf_in[4];
    endproperty
    a_scan_inputs: assert property (p_scan_inputs)
        else $error("scan pull-up or clock input wrong");

    property p_tdo_drive;
        @(posedge aclk) disable iff (!aresetn)
        scan_if_enable && shifting |-> pf_oe[6] && pf_out[6] == scan_tdo;
    endproperty
    a_tdo_drive: assert property (p_tdo_drive)
        else $error("test output not driven in shift state");

    property p_low_nibble_plain;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |-> pf_oe[3:0] == pf_dir[3:0] && pf_pullup[3:0]
            == (~pf_dir[3:0] & pf_data[3:0] & {4{!global_pullup_off}});
    endproperty
    a_low_nibble_plain: assert property (p_low_nibble_plain)
        else $error("port F low nibble overridden");

    property p_reset_pin;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |-> !pg_oe[5] && pg_pullup[5]
            && (reset_pin_disable_fuse || ext_reset_n);
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin handling wrong");

    property p_segment_23_drive;
        @(posedge aclk) disable iff (!aresetn)
        lcd_on && lcd_port_mask > 3'h5 |-> pg_oe[4] && !pg_pullup[4]
            && !counter_zero_ext_clock && lcd_seg_route[4];
    endproperty
    a_segment_23_drive: assert property (p_segment_23_drive)
        else $error("segment 23 takeover wrong");

    property p_pud_kills;
        @(posedge aclk) disable iff (!aresetn)
        global_pullup_off |-> pa_pullup == 8'h00;
    endproperty
    a_pud_kills: assert property (p_pud_kills)
        else $error("pull-up on while disabled");

    property p_mcu_reserved;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && rd_idx == pao_pkg::IDX_MCU |->
            rdata[6:5] == 2'b00 && rdata[3:2] == 2'b00
            && rdata[31:8] == 24'h00_0000;
    endproperty
    a_mcu_reserved: assert property (p_mcu_reserved)
        else $error("control register reserved bits set");

    property p_pa_out_write;
        @(posedge aclk) disable iff (!aresetn)
        w_lane && w_idx == pao_pkg::IDX_PA_OUT |=>
            port_a_output_data == $past(wdata[7:0]);
    endproperty
    a_pa_out_write: assert property (p_pa_out_write)
        else $error("port A output data not written");

    property p_pa_reset;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> pa_oe == 8'h00 && port_a_output_data == 8'h00;
    endproperty
    a_pa_reset: assert property (p_pa_reset)
        else $error("port A not all inputs after reset");

    property p_pa_pin_read;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid) && rd_idx == pao_pkg::IDX_PA_PIN |->
            rdata[7:0] == $past(pa_in);
    endproperty
    a_pa_pin_read: assert property (p_pa_pin_read)
        else $error("port A pin read mismatch");

    // Main scenarios
    c_scan_shift: cover property (@(posedge aclk)
        scan_if_enable && data_shift_state);
    c_lcd_full: cover property (@(posedge aclk)
        lcd_on && lcd_port_mask > 3'h6);
    c_pud_write: cover property (@(posedge aclk)
        w_lane && w_idx == pao_pkg::IDX_MCU && wdata[4]);
    c_pin_read: cover property (@(posedge aclk)
        rvalid && rready && rd_idx == pao_pkg::IDX_PA_PIN);

endmodule // pao_port_override

// *** pkg/pao_pkg.sv ***
// Purpose: Constants and carrier types for the port override block
// Assumes: 32-bit AXI4-Lite, register index times four is the byte address
// Notes:   Port A, F and G pins are flattened A first, then F, then G
package pao_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PA_PIN = 6'h00;
    localparam logic [5:0] IDX_PA_DIR = 6'h01;
    localparam logic [5:0] IDX_PA_OUT = 6'h02;
    localparam logic [5:0] IDX_PF_PIN = 6'h0F;
    localparam logic [5:0] IDX_PF_DIR = 6'h10;
    localparam logic [5:0] IDX_PF_OUT = 6'h11;
    localparam logic [5:0] IDX_PG_PIN = 6'h12;
    localparam logic [5:0] IDX_PG_DIR = 6'h13;
    localparam logic [5:0] IDX_PG_OUT = 6'h14;
    localparam logic [5:0] IDX_MCU    = 6'h35;

    // Control register fields and reset values
    localparam int         MCU_SCAN_DIS = 7;
    localparam int         MCU_PU_OFF   = 4;
    localparam int         MCU_VSEL     = 1;
    localparam int         MCU_VCE      = 0;
    localparam logic [7:0] MCU_RW_MASK  = 8'h93;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Pin counts and roles
    localparam int PA_W   = 8;
    localparam int PF_W   = 8;
    localparam int PG_W   = 6;
    localparam int NPIN   = PA_W + PF_W + PG_W;
    localparam int PF_TDI = 7;
    localparam int PF_TDO = 6;
    localparam int PF_TMS = 5;
    localparam int PF_TCK = 4;
    localparam int PG_RST = 5;
    localparam int PG_CK0 = 4;
    localparam int PG_CK1 = 3;

    // Port mask thresholds for the segment pins
    localparam logic [2:0] LCD_PM_G4  = 3'h5;
    localparam logic [2:0] LCD_PM_G3  = 3'h6;
    localparam logic [2:0] LCD_PM_G10 = 3'h0;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Override enables and values of one pin
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic direction_override_en;
        logic direction_override_val;
        logic out_value_override_en;
        logic out_value_override_val;
        logic input_enable_override_en;
        logic input_enable_override_val;
    } pao_ovr_type;

    localparam pao_ovr_type OVR_NONE = '0;

endpackage

// *** verilog/pao_pin_cell.sv ***
// Purpose: One pin's override mux between port registers and a function
// Assumes: Pin level already synchronous to the system clock
// Notes:   Purely combinational; the owner's registers sit in the top
module pao_pin_cell (
    input  wire pao_pkg::pao_ovr_type ovr,
    input  wire logic                 port_out,
    input  wire logic                 port_dir,
    input  wire logic                 pin_in,
    input  wire logic                 pullup_off,
    output logic                      pin_out,
    output logic                      pin_oe,
    output logic                      pin_pullup,
    output logic                      pin_din
);

    // Ordinary pull-up: input direction with output bit set
    wire norm_pullup = ~port_dir & port_out & ~pullup_off;

    // Override enable low leaves the port settings in charge
    assign pin_pullup = ovr.pullup_override_en
                      ? ovr.pullup_override_val : norm_pullup;
    assign pin_oe     = ovr.direction_override_en
                      ? ovr.direction_override_val : port_dir;
    assign pin_out    = ovr.out_value_override_en
                      ? ovr.out_value_override_val : port_out;

    // Disabled input reads low so a floating analog pin cannot toggle
    wire in_en = ovr.input_enable_override_en
               ? ovr.input_enable_override_val : 1'b1;
    assign pin_din = in_en & pin_in;

endmodule // pao_pin_cell

// *** bench/pao_pin_partner.sv ***
// Purpose: Pin and peripheral model facing the port override block
// Assumes: Pins packed port A bits 7:0, then F, then G
// Notes:   Undriven lines without pull-up toggle, so stale data never passes
module pao_pin_partner (
    input  wire logic        clk,
    input  wire logic [21:0] oe,
    input  wire logic [21:0] dout,
    input  wire logic [21:0] pu,
    input  wire logic [21:0] drv,
    input  wire logic [21:0] val,
    output logic      [21:0] lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] flt = 22'h00_0000;

    // Floating lines change every cycle
    always @(posedge clk) begin
        flt <= ~flt;
    end

    // Device drive wins, then tester drive on any pin selected by drv, then pull-up
    assign lvl = (oe & dout) | (~oe & drv & val)
               | (~oe & ~drv & (pu | flt));
endmodule // pao_pin_partner

// *** bench/pao_port_override_tb.sv ***
// Purpose: Self-checking bench for the port override block
// Assumes: Design answers on AXI4-Lite one cycle after taking a request
// Notes:   Pin outputs are sampled at the falling edge, where they settle
module pao_port_override_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  pa_out, pa_oe, pa_pullup, pf_out, pf_oe, pf_pullup;
    logic [5:0]  pg_out, pg_oe, pg_pullup;
    wire  [7:0]  pa_in, pf_in;
    wire  [5:0]  pg_in;
    wire  [21:0] lvl;
    logic        scan_fuse_en, instr_shift_state, data_shift_state, scan_tdo;
    logic        lcd_on, reset_pin_disable_fuse, scan_if_enable, scan_tdi;
    logic        scan_tms, scan_tck, counter_zero_ext_clock, ext_reset_n;
    logic        counter_one_ext_clock, global_pullup_off, vector_select;
    logic        vector_change_en;
    logic [2:0]  lcd_port_mask;
    logic [4:0]  lcd_seg_route;
    logic [21:0] drv, val;
    int          n_fail = 0, checked = 0, cyc = 0;

    assign {pg_in, pf_in, pa_in} = lvl;

    // Byte lanes above the low one are never used, so strobe is tied
    pao_port_override pao_port_override_inst (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pa_in, .pa_out, .pa_oe, .pa_pullup, .pf_in,
        .pf_out, .pf_oe, .pf_pullup, .pg_in, .pg_out, .pg_oe, .pg_pullup,
        .scan_fuse_en, .instr_shift_state, .data_shift_state, .scan_tdo,
        .lcd_on, .lcd_port_mask, .reset_pin_disable_fuse, .scan_if_enable,
        .scan_tdi, .scan_tms, .scan_tck, .counter_zero_ext_clock,
        .counter_one_ext_clock, .ext_reset_n, .lcd_seg_route,
        .global_pullup_off, .vector_select, .vector_change_en);

    pao_pin_partner pao_pin_partner_inst (.clk(aclk), .drv, .val, .lvl,
        .oe({pg_oe, pf_oe, pa_oe}), .dout({pg_out, pf_out, pa_out}),
        .pu({pg_pullup, pf_pullup, pa_pullup}));

    task automatic stop_test;
        $display("Checks %0d, failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] er = pao_pkg::RESP_OKAY);
        @(posedge aclk);
        awaddr <= {4'h0, idx, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (!bvalid);
        chk(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] er = pao_pkg::RESP_OKAY);
        @(posedge aclk);
        araddr <= {4'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        chk(rdata, {24'h00_0000, d});
        chk(rresp, er);
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic s_regs;
        rd(pao_pkg::IDX_PA_DIR, 8'h00);
        rd(pao_pkg::IDX_PA_OUT, 8'h00);
        rd(pao_pkg::IDX_MCU, 8'h00);
        rd(6'h03, 8'h00, pao_pkg::RESP_SLVERR);
        wr(6'h03, 8'hFF, pao_pkg::RESP_SLVERR);
        wr(pao_pkg::IDX_MCU, 8'hFF);
        rd(pao_pkg::IDX_MCU, 8'h93);
        chk({global_pullup_off, vector_select, vector_change_en},
            3'h7);
        wr(pao_pkg::IDX_MCU, 8'h00);
    endtask

    task automatic s_port_a_output_data;
        drv <= 22'h00_00FF;
        val <= 22'h00_005A;
        wr(pao_pkg::IDX_PA_OUT, 8'hA5);
        wr(pao_pkg::IDX_PA_DIR, 8'h3C);
        @(negedge aclk);
        chk(pa_oe, 8'h3C);
        chk(pa_out, 8'hA5);
        chk(pa_pullup, 8'h81);
        rd(pao_pkg::IDX_PA_PIN, 8'h66);
        wr(pao_pkg::IDX_MCU, 8'h10);
        @(negedge aclk);
        chk(pa_pullup, 8'h00);
        wr(pao_pkg::IDX_MCU, 8'h00);
    endtask

    task automatic s_scan;
        wr(pao_pkg::IDX_PF_DIR, 8'hFF);
        wr(pao_pkg::IDX_PF_OUT, 8'h0F);
        scan_fuse_en <= 1'b1;
        // Tester drives clock and data in high, mode select low
        drv <= 22'h00_B000;
        val <= 22'h00_9000;
        for (int k = 0; k < 4; k++) begin
            @(posedge aclk);
            {instr_shift_state, data_shift_state} <= k[1:0];
            scan_tdo <= ~k[0];
            @(negedge aclk);
            chk(pf_oe, {1'b0, k != 0, 6'h0F});
            chk(pf_out, {1'b0, ~k[0], 6'h0F});
            chk(pf_pullup[7:4], 4'hF);
            chk({scan_if_enable, scan_tck}, 2'h3);
            chk({scan_tdi, scan_tms}, 2'h2);
        end
        wr(pao_pkg::IDX_MCU, 8'h80);
        @(negedge aclk);
        chk({scan_if_enable, pf_oe}, 9'h0FF);
    endtask

    task automatic s_lcd;
        logic [4:0] e;
        drv <= 22'h3F_0000;
        val <= 22'h1F_0000;
        reset_pin_disable_fuse <= 1'b1;
        // Data bits set so unowned pins show their ordinary pull-ups
        wr(pao_pkg::IDX_PG_OUT, 8'h1F);
        for (int m = 0; m < 9; m++) begin
            @(posedge aclk);
            lcd_port_mask <= m[2:0];
            lcd_on <= (m < 8);
            @(negedge aclk);
            e = (m < 8) ? {m > 5, m > 6, 1'b1, m > 0, m > 0} : 5'h00;
            chk(lcd_seg_route, e);
            chk(pg_oe, {1'b0, e[4], 4'h0});
            chk(pg_pullup, {1'b1, ~e});
            chk(pg_out, 6'h1F);
            chk({counter_zero_ext_clock, counter_one_ext_clock},
                {~e[4], ~e[3]});
        end
        chk(ext_reset_n, 1'b0);
        @(posedge aclk);
        reset_pin_disable_fuse <= 1'b0;
        @(negedge aclk);
        chk(ext_reset_n, 1'b1);
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Cuts a hang short; the full run needs about seventy cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            stop_test;
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
        {awaddr, araddr, wdata, drv, val} <= '0;
        {scan_fuse_en, instr_shift_state, data_shift_state, scan_tdo} <= 4'h0;
        {lcd_on, lcd_port_mask, reset_pin_disable_fuse} <= 5'h01;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs;
        s_port_a_output_data;
        s_scan;
        s_lcd;
        stop_test;
    end
endmodule // pao_port_override_tb
